/* File: hdl/pcm_clock_power.v */
`timescale 1ns/100ps
`include "pcm_consts.vh"
module pcm_clock_power (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire main_clk_pin,
  input wire sub_clk_pin,
  input wire oco_clk_pin,
  input wire sub_run,
  input wire oco_run,
  input wire wait_mode,
  input wire port_out,
  input wire port_oe,
  output reg periph_clk_div1,
  output reg periph_clk_div8,
  output reg periph_clk_div32,
  output reg periph_clk_prog,
  output reg converter_clk,
  output reg lowspeed_timer_clk,
  output reg base_clk,
  output reg cpu_clk,
  output reg clock_output_pin,
  output reg clock_output_oe,
  output reg main_osc_run,
  output reg pll_run,
  output reg pll_ref_en,
  output reg main_regulator_on,
  output reg [2:0] clock_mode
);
  // Control registers
  reg [1:0] clock_output_pin_sel;
  reg wait_clock_stop;
  reg main_osc_stop;
  reg clock_write_protect;
  reg [1:0] periph_div_sel;
  reg div2n_source_sel;
  reg [3:0] div2n_value;
  reg [1:0] base_div_sel;
  reg [1:0] cpu_div_sel;
  reg base_src_low;
  reg lowspeed_sel_oco;
  reg pll_self_osc;
  reg regulator_stop;

  // Bus data phase
  reg pend;
  reg pend_write;
  reg [7:0] pend_addr;

  // Pin synchronisers: three stages, a level counts once stages 2 and 3 agree
  wire [2:0] pin_in;
  reg [2:0] sync1;
  reg [2:0] sync2;
  reg [2:0] sync3;
  reg [2:0] pin_level;
  wire [2:0] pin_rise;
  assign pin_in = {oco_clk_pin, sub_clk_pin, main_clk_pin};

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gen_sync
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
          sync3[g] <= 1'b0;
          pin_level[g] <= 1'b0;
        end else begin
          sync1[g] <= pin_in[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
          if (sync2[g] == sync3[g]) begin
            pin_level[g] <= sync3[g];
          end
        end
      end
      assign pin_rise[g] = (sync2[g] == sync3[g]) && sync3[g] && !pin_level[g];
    end
  endgenerate

  // Mode decode
  wire low_power = base_src_low && main_osc_stop;
  wire main_tick = pin_rise[0] && !main_osc_stop;
  wire periph_stop = low_power || (wait_mode && wait_clock_stop);
  reg [2:0] next_mode;
  always @* begin
    if (base_src_low) begin
      next_mode = low_power ? `PCM_MODE_LPWR : `PCM_MODE_LOW;
    end else if (pll_self_osc) begin
      next_mode = `PCM_MODE_SELF;
    end else if (base_div_sel == 2'h0) begin
      next_mode = `PCM_MODE_HIGH;
    end else begin
      next_mode = `PCM_MODE_MED;
    end
  end

  // Peripheral clock source from the PLL-rate clock
  reg [2:0] ps_cnt;
  wire [2:0] ps_last = {periph_div_sel, 1'b1};
  wire ps_tick = !periph_stop && (ps_cnt == ps_last);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ps_cnt <= 3'h0;
    end else if (periph_stop) begin
      ps_cnt <= 3'h0;
    end else if (ps_cnt >= ps_last) begin
      ps_cnt <= 3'h0;
    end else begin
      ps_cnt <= ps_cnt + 3'h1;
    end
  end

  // Fixed dividers off the source; counter bits also give square waves for the pin
  reg [4:0] fix_cnt;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fix_cnt <= 5'h00;
    end else if (ps_tick) begin
      fix_cnt <= fix_cnt + 5'h01;
    end
  end
  wire div8_tick = ps_tick && (fix_cnt[2:0] == 3'h7);
  wire div32_tick = ps_tick && (fix_cnt == 5'h1F);

  // Programmable 2n divider
  wire d2n_in = div2n_source_sel ? main_tick : ps_tick;
  reg [4:0] d2n_cnt;
  wire [4:0] d2n_last = {div2n_value, 1'b1} - 5'h02;
  wire d2n_tick = (div2n_value == 4'h0) ? d2n_in : (d2n_in && (d2n_cnt >= d2n_last));
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      d2n_cnt <= 5'h00;
    end else if (d2n_in) begin
      if (div2n_value == 4'h0 || d2n_cnt >= d2n_last) begin
        d2n_cnt <= 5'h00;
      end else begin
        d2n_cnt <= d2n_cnt + 5'h01;
      end
    end
  end

  // Low speed sources: sub clock edges, on-chip osc /4 and /128
  reg [4:0] sub_cnt;
  reg [6:0] oco_cnt;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sub_cnt <= 5'h00;
      oco_cnt <= 7'h00;
    end else begin
      if (pin_rise[1]) begin
        sub_cnt <= sub_cnt + 5'h01;
      end
      if (pin_rise[2]) begin
        oco_cnt <= oco_cnt + 7'h01;
      end
    end
  end
  wire oco4_tick = pin_rise[2] && (oco_cnt[1:0] == 2'h3);
  wire ls_tick = lowspeed_sel_oco ? oco4_tick : pin_rise[1];
  wire ls_run = lowspeed_sel_oco ? oco_run : sub_run;
  // Only valid while the chosen oscillator runs
  wire tmr_tick = lowspeed_sel_oco ? (oco_run && pin_rise[2] && oco_cnt == 7'h7F)
                                   : (sub_run && pin_rise[1] && sub_cnt == 5'h1F);
  reg ls_wave;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ls_wave <= 1'b0;
    end else if (ls_tick && ls_run) begin
      ls_wave <= !ls_wave;
    end
  end

  // Base clock: PLL/2,3,4,6 or the low speed clock; stops in wait mode
  reg [2:0] bc_cnt;
  reg [2:0] bc_last;
  always @* begin
    case (base_div_sel)
      2'h0: bc_last = 3'h1;
      2'h1: bc_last = 3'h2;
      2'h2: bc_last = 3'h3;
      default: bc_last = 3'h5;
    endcase
  end
  wire pll_tick = !low_power && (bc_cnt >= bc_last);
  wire base_tick = !wait_mode && (base_src_low ? (ls_tick && ls_run) : pll_tick);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bc_cnt <= 3'h0;
    end else if (low_power || bc_cnt >= bc_last) begin
      bc_cnt <= 3'h0;
    end else begin
      bc_cnt <= bc_cnt + 3'h1;
    end
  end

  // CPU clock: base/1..4, forced to base rate in high speed mode
  reg [1:0] cc_cnt;
  wire [1:0] cc_last = (next_mode == `PCM_MODE_HIGH) ? 2'h0 : cpu_div_sel;
  wire cpu_tick = base_tick && (cc_cnt >= cc_last);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cc_cnt <= 2'h0;
    end else if (base_tick) begin
      cc_cnt <= (cc_cnt >= cc_last) ? 2'h0 : cc_cnt + 2'h1;
    end
  end

  // Registered clock and status outputs
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      periph_clk_div1 <= 1'b0;
      periph_clk_div8 <= 1'b0;
      periph_clk_div32 <= 1'b0;
      periph_clk_prog <= 1'b0;
      converter_clk <= 1'b0;
      lowspeed_timer_clk <= 1'b0;
      base_clk <= 1'b0;
      cpu_clk <= 1'b0;
      clock_output_pin <= 1'b0;
      clock_output_oe <= 1'b0;
      main_osc_run <= 1'b1;
      pll_run <= 1'b1;
      pll_ref_en <= 1'b1;
      main_regulator_on <= 1'b1;
      clock_mode <= `PCM_MODE_MED;
    end else begin
      periph_clk_div1 <= ps_tick;
      periph_clk_div8 <= div8_tick;
      periph_clk_div32 <= div32_tick;
      periph_clk_prog <= d2n_tick;
      converter_clk <= ps_tick;
      lowspeed_timer_clk <= tmr_tick;
      base_clk <= base_tick;
      cpu_clk <= cpu_tick;
      // Divided waves hold their level while the source is stopped
      case (clock_output_pin_sel)
        2'h0: clock_output_pin <= port_out;
        2'h1: clock_output_pin <= ls_wave;
        2'h2: clock_output_pin <= fix_cnt[2];
        default: clock_output_pin <= fix_cnt[4];
      endcase
      clock_output_oe <= (clock_output_pin_sel == 2'h0) ? port_oe : 1'b1;
      main_osc_run <= !main_osc_stop;
      pll_run <= !low_power;
      pll_ref_en <= !pll_self_osc && !main_osc_stop;
      main_regulator_on <= !(low_power && regulator_stop);
      clock_mode <= next_mode;
    end
  end

  // Read decode, used for the data phase answer
  function [31:0] pcm_read;
    input [7:0] a;
    begin
      case (a)
        `PCM_CTRL0_OFF: pcm_read = {26'h0, main_osc_stop, 2'h0, wait_clock_stop, clock_output_pin_sel};
        `PCM_PROT_OFF: pcm_read = {31'h0, clock_write_protect};
        `PCM_PDIV_OFF: pcm_read = {29'h0, div2n_source_sel, periph_div_sel};
        `PCM_PRESC_OFF: pcm_read = {28'h0, div2n_value};
        `PCM_CCFG_OFF: pcm_read = {26'h0, lowspeed_sel_oco, base_src_low, cpu_div_sel, base_div_sel};
        `PCM_PLL_OFF: pcm_read = {30'h0, regulator_stop, pll_self_osc};
        `PCM_STAT_OFF: pcm_read = {27'h0, ls_run, low_power, clock_mode};
        default: pcm_read = 32'h0;
      endcase
    end
  endfunction

  // AHB-Lite slave: one wait cycle per transfer so reads never race a write
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      pend <= 1'b0;
      pend_write <= 1'b0;
      pend_addr <= 8'h0;
      clock_output_pin_sel <= 2'h0;
      wait_clock_stop <= 1'b0;
      main_osc_stop <= 1'b0;
      clock_write_protect <= 1'b0;
      periph_div_sel <= 2'h0;
      div2n_source_sel <= 1'b0;
      div2n_value <= 4'h0;
      base_div_sel <= `PCM_BDIV_RST;
      cpu_div_sel <= `PCM_CDIV_RST;
      base_src_low <= 1'b0;
      lowspeed_sel_oco <= 1'b0;
      pll_self_osc <= 1'b0;
      regulator_stop <= 1'b0;
    end else if (pend) begin
      pend <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= pend_write ? 32'h0 : pcm_read(pend_addr);
      if (pend_write) begin
        case (pend_addr)
          `PCM_CTRL0_OFF: begin
            if (clock_write_protect) begin
              clock_output_pin_sel <= hwdata[`PCM_CLOCK_OUTPUT_PIN_LSB +: 2];
            end
            wait_clock_stop <= hwdata[`PCM_WSTOP_BIT];
            main_osc_stop <= hwdata[`PCM_MOSTOP_BIT];
          end
          `PCM_PROT_OFF: clock_write_protect <= hwdata[`PCM_WPROT_BIT];
          `PCM_PDIV_OFF: begin
            periph_div_sel <= hwdata[`PCM_PDSEL_LSB +: 2];
            div2n_source_sel <= hwdata[`PCM_D2NSRC_BIT];
          end
          `PCM_PRESC_OFF: div2n_value <= hwdata[`PCM_D2N_LSB +: 4];
          `PCM_CCFG_OFF: begin
            base_div_sel <= hwdata[`PCM_BDIV_LSB +: 2];
            cpu_div_sel <= hwdata[`PCM_CDIV_LSB +: 2];
            base_src_low <= hwdata[`PCM_BSRC_BIT];
            lowspeed_sel_oco <= hwdata[`PCM_LSSEL_BIT];
          end
          `PCM_PLL_OFF: begin
            pll_self_osc <= hwdata[`PCM_SEO_BIT];
            regulator_stop <= hwdata[`PCM_REGSTOP_BIT];
          end
          default: ;
        endcase
      end
    end else if (hsel && htrans[1] && hready) begin
      pend <= 1'b1;
      hreadyout <= 1'b0;
      pend_write <= hwrite;
      pend_addr <= {haddr[7:2], 2'h0};
    end
  end
endmodule

/* File: hdl/pcm_consts.vh */
`ifndef PCM_CONSTS_VH
`define PCM_CONSTS_VH
// Register byte offsets
`define PCM_CTRL0_OFF 8'h00
`define PCM_PROT_OFF 8'h04
`define PCM_PDIV_OFF 8'h08
`define PCM_PRESC_OFF 8'h0C
`define PCM_CCFG_OFF 8'h10
`define PCM_PLL_OFF 8'h14
`define PCM_STAT_OFF 8'h18
// Field positions
`define PCM_CLOCK_OUTPUT_PIN_LSB 0
`define PCM_WSTOP_BIT 2
`define PCM_MOSTOP_BIT 5
`define PCM_WPROT_BIT 0
`define PCM_PDSEL_LSB 0
`define PCM_D2NSRC_BIT 2
`define PCM_D2N_LSB 0
`define PCM_BDIV_LSB 0
`define PCM_CDIV_LSB 2
`define PCM_BSRC_BIT 4
`define PCM_LSSEL_BIT 5
`define PCM_SEO_BIT 0
`define PCM_REGSTOP_BIT 1
// Reset values
`define PCM_BDIV_RST 2'h3
`define PCM_CDIV_RST 2'h1
// Mode codes
`define PCM_MODE_HIGH 3'h0
`define PCM_MODE_MED 3'h1
`define PCM_MODE_LOW 3'h2
`define PCM_MODE_LPWR 3'h3
`define PCM_MODE_SELF 3'h4
`endif

/* File: test/pcm_chk.sv */
`timescale 1ns/100ps
module pcm_chk (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire sub_run,
  input wire oco_run,
  input wire periph_clk_div1,
  input wire periph_clk_div8,
  input wire converter_clk,
  input wire lowspeed_timer_clk,
  input wire base_clk,
  input wire cpu_clk,
  input wire pll_run,
  input wire main_regulator_on,
  input wire [2:0] clock_mode
);
  reg [3:0] idle;
  // Give the pin synchronisers time to drain before a missing tick is demanded
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      idle <= 4'h0;
    else if (sub_run || oco_run)
      idle <= 4'h0;
    else if (idle != 4'hF)
      idle <= idle + 4'h1;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  bus_wait_a: assert property (hsel && htrans[1] && hready && hreadyout |=> !hreadyout ##1 hreadyout)
    else $error("bus wait state wrong");
  bus_okay_a: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  src_gap_a: assert property (periph_clk_div1 |=> !periph_clk_div1)
    else $error("source ticks too close");
  div8_align_a: assert property (periph_clk_div8 |-> periph_clk_div1)
    else $error("div8 tick off the source tick");
  conv_rate_a: assert property ($rose(converter_clk) |-> periph_clk_div1)
    else $error("converter tick off the source tick");
  lp_gate_a: assert property ((clock_mode == 3'h3) [*3] |-> !periph_clk_div1 && !converter_clk)
    else $error("peripheral tick in low power");
  lp_osc_a: assert property ((clock_mode == 3'h3) [*2] |-> !pll_run)
    else $error("pll runs in low power");
  hs_cpu_a: assert property ((clock_mode == 3'h0) [*2] |-> cpu_clk == base_clk)
    else $error("cpu clock differs from base");
  ts_valid_a: assert property (idle > 4'h5 |-> !lowspeed_timer_clk)
    else $error("timer clock without oscillator");
  reg_stop_a: assert property (!main_regulator_on |-> clock_mode == 3'h3 || $past(clock_mode) == 3'h3)
    else $error("regulator off outside low power");
  cover property (clock_mode == 3'h4);
  cover property (clock_mode == 3'h3 && !main_regulator_on);
  cover property (periph_clk_div8 && periph_clk_div1);
endmodule
bind pcm_clock_power pcm_chk i_chk (.hclk, .hresetn, .hsel, .htrans, .hready, .hreadyout, .hresp, .sub_run,
  .oco_run, .periph_clk_div1, .periph_clk_div8, .converter_clk, .lowspeed_timer_clk, .base_clk, .cpu_clk,
  .pll_run, .main_regulator_on, .clock_mode);

/* File: test/pcm_osc_model.sv */
`timescale 1ns/100ps
module pcm_osc_model #(
  parameter MAIN_NS = 400,
  parameter SUB_NS = 480,
  parameter OCO_NS = 640
) (
  input wire main_en,
  input wire sub_en,
  input wire oco_en,
  output logic main_clk_pin,
  output logic sub_clk_pin,
  output logic oco_clk_pin,
  output wire sub_run,
  output wire oco_run
);
  initial main_clk_pin = 1'b0;
  initial sub_clk_pin = 1'b0;
  initial oco_clk_pin = 1'b0;
  // Half periods are whole multiples of the bus clock period so pin edges never meet a rising edge
  // A stopped oscillator rests low rather than holding its last level
  always #(MAIN_NS / 2) main_clk_pin = main_en ? ~main_clk_pin : 1'b0;
  always #(SUB_NS / 2) sub_clk_pin = sub_en ? ~sub_clk_pin : 1'b0;
  always #(OCO_NS / 2) oco_clk_pin = oco_en ? ~oco_clk_pin : 1'b0;
  assign sub_run = sub_en;
  assign oco_run = oco_en;
endmodule

/* File: test/tb_top.sv */
`timescale 1ns/100ps
`include "pcm_consts.vh"
module tb_top;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, wait_mode = 1'b0;
  logic port_out = 1'b1, port_oe = 1'b0, sub_en = 1'b1, oco_en = 1'b1;
  logic [1:0] htrans = 2'h0, s;
  logic [2:0] hsize = 3'h2;
  logic [3:0] n;
  logic [7:0] haddr = 8'h00, r = 8'h0E;
  logic [31:0] hwdata = 32'h0, rd;
  wire [31:0] hrdata;
  wire [7:0] ck;
  wire [2:0] clock_mode;
  wire hreadyout, hresp, main_clk_pin, sub_clk_pin, oco_clk_pin, sub_run, oco_run;
  wire clock_output_pin, clock_output_oe, main_osc_run, pll_run, pll_ref_en, main_regulator_on;
  int err_total = 0, total_checks = 0, p;
  always #20 hclk = ~hclk;
  pcm_clock_power i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .main_clk_pin, .sub_clk_pin, .oco_clk_pin, .sub_run, .oco_run, .wait_mode,
    .port_out, .port_oe, .periph_clk_div1(ck[0]), .periph_clk_div8(ck[1]), .periph_clk_div32(ck[2]),
    .periph_clk_prog(ck[3]), .converter_clk(ck[4]), .lowspeed_timer_clk(ck[5]), .base_clk(ck[6]), .cpu_clk(ck[7]),
    .clock_output_pin, .clock_output_oe, .main_osc_run, .pll_run, .pll_ref_en, .main_regulator_on, .clock_mode);
  pcm_osc_model i_osc (.main_en(main_osc_run), .sub_en, .oco_en, .main_clk_pin, .sub_clk_pin, .oco_clk_pin,
    .sub_run, .oco_run);
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic int src_exp(input logic [1:0] sel);
    return 2 * sel + 2;
  endfunction
  function automatic int prog_exp(input int src, input logic [3:0] nv);
    return (nv == 4'h0) ? src : 2 * nv * src;
  endfunction
  task report_and_stop;
    if (err_total == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Pin-fed clocks pass a synchroniser, so a single period may slip by a cycle or two
  task near(input int a, input int e);
    chk(a >= e - 2 && a <= e + 2, 1);
  endtask
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int w;
    w = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++w < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++w < 50);
    rd = hrdata;
    if (w >= 50)
      chk(w, 0);
  endtask
  task per(input int k, output int c);
    int w;
    w = 0;
    do @(posedge hclk); while (ck[k] !== 1'b1 && ++w < 3000);
    c = 0;
    do begin
      @(posedge hclk);
      c++;
    end while (ck[k] !== 1'b1 && c < 3000);
  endtask
  // Rise-to-rise period of the clock output pin, in bus clock cycles
  task pin_per(output int c);
    logic q;
    int w;
    w = 0;
    do begin
      q = clock_output_pin;
      @(posedge hclk);
    end while (!(q === 1'b0 && clock_output_pin === 1'b1) && ++w < 3000);
    c = 0;
    do begin
      q = clock_output_pin;
      @(posedge hclk);
      c++;
    end while (!(q === 1'b0 && clock_output_pin === 1'b1) && c < 3000);
  endtask
  task cnt(input int k, input int len, output int c);
    c = 0;
    repeat (4) @(posedge hclk);
    repeat (len) begin
      @(posedge hclk);
      c += (ck[k] === 1'b1);
    end
  endtask
  initial begin
    #2_000_000;
    err_total++;
    report_and_stop;
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(0, `PCM_STAT_OFF, 0);
    chk(rd[2:0], `PCM_MODE_MED);
    bus(0, 8'h1C, 0);
    chk(rd, 0);
    for (int i = 0; i < 6; i++) begin
      r = lfsr(r);
      s = (i == 0) ? 2'h3 : (i == 1) ? 2'h0 : r[1:0];
      n = (i == 0) ? 4'hF : (i == 1) ? 4'h0 : r[5:2];
      port_out <= r[6];
      bus(1, `PCM_PDIV_OFF, s);
      bus(1, `PCM_PRESC_OFF, n);
      per(0, p);
      chk(p, src_exp(s));
      per(1, p);
      chk(p, 8 * src_exp(s));
      per(3, p);
      chk(p, prog_exp(src_exp(s), n));
    end
    per(2, p);
    chk(p, 32 * src_exp(s));
    per(4, p);
    chk(p, src_exp(s));
    bus(1, `PCM_PRESC_OFF, 1);
    bus(1, `PCM_PDIV_OFF, 4 + s);
    per(3, p);
    near(p, 20);
    bus(1, `PCM_CTRL0_OFF, 2);
    bus(0, `PCM_CTRL0_OFF, 0);
    chk(rd[1:0], 2'h0);
    chk(clock_output_oe, 1'b0);
    bus(1, `PCM_PROT_OFF, 1);
    for (int c = 1; c < 4; c++) begin
      bus(1, `PCM_CTRL0_OFF, c);
      bus(0, `PCM_CTRL0_OFF, 0);
      chk(rd[1:0], c);
      chk(clock_output_oe, 1'b1);
      pin_per(p);
      if (c == 1)
        near(p, 24);
      else
        chk(p, (c == 2 ? 8 : 32) * src_exp(s));
    end
    port_oe <= 1'b1;
    bus(1, `PCM_CTRL0_OFF, 0);
    bus(0, `PCM_CTRL0_OFF, 0);
    chk({clock_output_oe, clock_output_pin}, {1'b1, port_out});
    bus(1, `PCM_CTRL0_OFF, 4);
    wait_mode <= 1'b1;
    cnt(0, 40, p);
    chk(p, 0);
    bus(1, `PCM_CTRL0_OFF, 0);
    cnt(0, 40, p);
    chk(p != 0, 1);
    wait_mode <= 1'b0;
    bus(1, `PCM_PLL_OFF, 1);
    bus(0, `PCM_STAT_OFF, 0);
    chk({rd[2:0], pll_ref_en}, {`PCM_MODE_SELF, 1'b0});
    per(0, p);
    chk(p, src_exp(s));
    bus(1, `PCM_PDIV_OFF, 3);
    bus(1, `PCM_PLL_OFF, 0);
    bus(1, `PCM_CCFG_OFF, 0);
    bus(0, `PCM_STAT_OFF, 0);
    chk(clock_mode, `PCM_MODE_HIGH);
    per(7, p);
    chk(p, 2);
    bus(1, `PCM_CCFG_OFF, 8'h0E);
    per(6, p);
    chk(p, 4);
    per(7, p);
    chk(p, 16);
    bus(1, `PCM_CCFG_OFF, 8'h10);
    bus(0, `PCM_STAT_OFF, 0);
    chk(clock_mode, `PCM_MODE_LOW);
    per(6, p);
    near(p, 12);
    bus(1, `PCM_PLL_OFF, 1);
    bus(1, `PCM_CTRL0_OFF, 32);
    bus(0, `PCM_STAT_OFF, 0);
    chk({clock_mode, main_osc_run, main_regulator_on}, {`PCM_MODE_LPWR, 2'b01});
    per(5, p);
    near(p, 384);
    bus(1, `PCM_CCFG_OFF, 8'h30);
    per(6, p);
    near(p, 64);
    per(5, p);
    near(p, 2048);
    bus(1, `PCM_PLL_OFF, 3);
    bus(0, `PCM_STAT_OFF, 0);
    chk(main_regulator_on, 1'b0);
    sub_en <= 1'b0;
    oco_en <= 1'b0;
    cnt(5, 800, p);
    chk(p, 0);
    report_and_stop;
  end
endmodule
